// File: logic/dacip_pkg.sv
// constants shared by the audio input and control port design
package dacip_pkg;
  // mode, status and period register indices reached by the serial port and the bus
  localparam logic [6:0] IDX_ATTN_LEFT   = 7'h10;
  localparam logic [6:0] IDX_ATTN_RIGHT  = 7'h11;
  localparam logic [6:0] IDX_FORMAT_CTRL = 7'h12;
  localparam logic [6:0] IDX_OUTPUT_CTRL = 7'h13;
  localparam logic [6:0] IDX_MODE_CTRL   = 7'h14;
  localparam logic [6:0] IDX_ZERO_CTRL   = 7'h15;
  localparam logic [6:0] IDX_STATUS      = 7'h40;
  localparam logic [6:0] IDX_PERIOD      = 7'h41;
  localparam logic [6:0] MODE_FIRST      = IDX_ATTN_LEFT;
  localparam int         MODE_COUNT      = 6;
  localparam logic [7:0] MODE_RST [MODE_COUNT] =
    '{8'h00, 8'h00, 8'h50, 8'h00, 8'h00, 8'h00};
  // field positions
  localparam int FMT_LSB        = 4;
  localparam int STEREO_SEL_BIT = 2;
  localparam int BYPASS_BIT     = 4;
  localparam int STREAM_BIT     = 5;
  // input format codes
  localparam logic [2:0] FMT_RJ16  = 3'h0;
  localparam logic [2:0] FMT_RJ20  = 3'h1;
  localparam logic [2:0] FMT_RJ24  = 3'h2;
  localparam logic [2:0] FMT_LJ24  = 3'h3;
  localparam logic [2:0] FMT_I2S16 = 3'h4;
  localparam logic [2:0] FMT_I2S24 = 3'h5;
  localparam int         SAMPLE_W  = 24;
  // system clock ratio detection
  localparam int         INIT_CYCLES      = 1024;
  localparam int         RATIO_COUNT      = 6;
  localparam logic [10:0] RATIOS [RATIO_COUNT] =
    '{11'h080, 11'h0c0, 11'h100, 11'h180, 11'h200, 11'h300};
  localparam logic [10:0] RATIO_TOL       = 11'h004;
  localparam logic [2:0]  RATIO_NONE      = 3'h7;
  localparam int          DRIFT_BIT_CLKS  = 6;
  // serial control word
  localparam int CTRL_WORD_BITS = 16;
  localparam int CTRL_HALF_BITS = 8;
  // bus address: register index sits above the byte lanes
  localparam int ADDR_LSB = 2;
  typedef enum logic {LOCK_SEARCH, LOCK_HELD} dacip_lock_e;
endpackage

// File: logic/dacip_sync2.sv
// two-flop synchroniser for a group of pin inputs
`timescale 1ns/10ps
module dacip_sync2 #(
  parameter int               WIDTH     = 1,
  parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
  // clock and reset
  input  wire logic             clk,
  input  wire logic             reset_n,
  // pins and synchronised copies
  input  wire logic [WIDTH-1:0] pin,
  output logic      [WIDTH-1:0] sync
);
  logic [WIDTH-1:0] meta;

  // meta feeds only the second stage
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      meta <= RESET_VAL;
      sync <= RESET_VAL;
    end else begin
      meta <= pin;
      sync <= meta;
    end
  end
endmodule

// File: logic/dacip_ctrl_port.sv
// four-wire serial control port, oversampled by the system clock
`timescale 1ns/10ps
module dacip_ctrl_port (
  // clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // synchronised control pins
  input  wire logic       sclk,
  input  wire logic       sel_n,
  input  wire logic       sdi,
  // register access
  output logic      [6:0] index,
  input  wire logic [7:0] rd_data,
  output logic            wr_pulse,
  output logic      [7:0] wr_data,
  // serial data out, enable low while driving
  output logic            sdo,
  output logic            sdo_oe_n
);
  localparam int CTRL_WORD_BITS = dacip_pkg::CTRL_WORD_BITS;
  localparam int CTRL_HALF_BITS = dacip_pkg::CTRL_HALF_BITS;
  logic        sclk_prev;
  logic [4:0]  cnt;
  logic [15:0] word;
  logic        is_read;
  logic        loaded;
  logic        wr_done;
  logic [7:0]  out_sr;
  logic        rise;
  logic        fall;

  assign rise    = sclk & ~sclk_prev;
  assign fall    = ~sclk & sclk_prev;
  assign index   = (cnt == 5'(CTRL_WORD_BITS)) ? word[14:8] : word[6:0];
  assign wr_data = word[7:0];

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) sclk_prev <= 1'b0;
    else          sclk_prev <= sclk;
  end

  // select high ends the word, so every word starts fresh
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt  <= '0;
      word <= '0;
    end else if (sel_n) begin
      cnt <= '0;
    end else if (rise && cnt < 5'(CTRL_WORD_BITS)) begin
      word <= {word[14:0], sdi};
      cnt  <= cnt + 5'h01;
    end
  end

  // read data fetched once the index byte is complete
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      is_read <= 1'b0;
      loaded  <= 1'b0;
      out_sr  <= '0;
    end else if (sel_n) begin
      is_read <= 1'b0;
      loaded  <= 1'b0;
    end else if (cnt == 5'(CTRL_HALF_BITS) && !loaded) begin
      loaded  <= 1'b1;
      is_read <= word[7];
      out_sr  <= rd_data;
    end else if (fall && is_read && cnt >= 5'(CTRL_HALF_BITS)
                 && cnt < 5'(CTRL_WORD_BITS)) begin
      out_sr <= {out_sr[6:0], 1'b0};
    end
  end

  // output moves only after falling edges, or clears when select goes high
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      sdo      <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (sel_n) begin
      sdo      <= 1'b0;
      sdo_oe_n <= 1'b1;
    end else if (fall && is_read && cnt >= 5'(CTRL_HALF_BITS)
                 && cnt < 5'(CTRL_WORD_BITS)) begin
      sdo      <= out_sr[7];
      sdo_oe_n <= 1'b0;
    end
  end

  // write lands once, after the sixteenth clock
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_pulse <= 1'b0;
      wr_done  <= 1'b0;
    end else begin
      wr_pulse <= !sel_n && cnt == 5'(CTRL_WORD_BITS) && !word[15]
                  && !wr_done;
      if (sel_n) wr_done <= 1'b0;
      else if (cnt == 5'(CTRL_WORD_BITS)) wr_done <= 1'b1;
    end
  end
endmodule

// File: logic/dacip_top.sv
// audio input port, clock ratio detection, init and mode registers
// How it works
// - detect system clock to sample rate ratio, 128 through 768.
// - after power-on, run 1024-cycle init, then default state.
// - reset held low 20 ns; release starts 1024-cycle init.
// - audio bits shift in on each rising bit clock edge.
// - drift beyond six bit clocks reinitialises and mutes until relock; here it drops the lock and mutes, with no new init run.
// - three-bit format field in register 18, default 24-bit I2S.
// - samples are two's complement, most significant bit first.
// - left-justified high word clock is left; I2S low is left.
// - bypass bit in register 20 turns pins to external filter port.
// - bypass with stereo bit of register 19 uses stream data pins.
// - stream mode samples both data pins on rising stream clock.
// - stream bit in register 20 selects one-bit stream mode.
// - control port runs on its own clock, asynchronous to all.
// - 16-bit word: read bit, seven-bit index, eight data bits.
// - on reads, register data driven out after eighth clock.
// - on writes, data loaded only after the sixteenth clock.
//
// Implementation choices: the Avalon-MM register port and the placing of the registers.
`timescale 1ns/10ps
module dacip_top #(
  parameter int          INIT_CYCLES         = dacip_pkg::INIT_CYCLES,
  parameter int          BITS_PER_FRAME_LOG2 = 6,
  parameter logic [10:0] RATIO_TOL           = dacip_pkg::RATIO_TOL
) (
  // clock and reset
  input  wire logic        CLK,
  input  wire logic        RESET_N,
  // register bus
  input  wire logic [8:0]  AVS_ADDRESS,
  input  wire logic        AVS_READ,
  input  wire logic        AVS_WRITE,
  input  wire logic [31:0] AVS_WRITEDATA,
  output logic      [31:0] AVS_READDATA,
  output logic             AVS_WAITREQUEST,
  // audio pins
  input  wire logic        PCM_WORD_CLOCK,
  input  wire logic        PCM_BIT_CLOCK,
  input  wire logic        PCM_SERIAL_DATA,
  input  wire logic        STREAM_LEFT_DATA,
  input  wire logic        STREAM_RIGHT_DATA,
  input  wire logic        STREAM_BIT_CLOCK,
  // serial control pins
  input  wire logic        CTRL_CLOCK,
  input  wire logic        CTRL_SELECT_N,
  input  wire logic        CTRL_DATA_IN,
  output logic             CTRL_DATA_OUT,
  output logic             CTRL_DATA_OE_N,
  // decoded audio
  output logic      [23:0] LEFT_SAMPLE,
  output logic      [23:0] RIGHT_SAMPLE,
  output logic             SAMPLE_VALID,
  output logic             STREAM_LEFT_BIT,
  output logic             STREAM_RIGHT_BIT,
  output logic             STREAM_VALID,
  // status
  output logic             INIT_BUSY,
  output logic             OUTPUT_MUTED
);
  generate
    if (INIT_CYCLES < 1 || INIT_CYCLES > 2047)
      $error("INIT_CYCLES must lie in 1..2047");
    if (BITS_PER_FRAME_LOG2 < 1 || BITS_PER_FRAME_LOG2 > 7)
      $error("BITS_PER_FRAME_LOG2 must lie in 1..7");
  endgenerate

  localparam logic [10:0] INIT_LAST = 11'(INIT_CYCLES - 1);

  logic [8:0]  pins_s;
  logic        wclk_s, bclk_s, pdat_s, sl_s, sr_s, sbclk_s;
  logic        cclk_s, csel_s, cdin_s;
  logic [7:0]  mode_reg [dacip_pkg::MODE_COUNT];
  logic [10:0] init_cnt;
  logic [6:0]  ctrl_idx;
  logic        ctrl_wr;
  logic [7:0]  ctrl_wdata;
  logic [15:0] ctrl_rd16;
  logic [6:0]  bus_idx;
  logic        bus_wr;

  // every pin is foreign to CLK; control pins idle with select high
  dacip_sync2 #(.WIDTH(9), .RESET_VAL(9'h002)) u_sync (
    .clk     (CLK),
    .reset_n (RESET_N),
    .pin     ({PCM_WORD_CLOCK, PCM_BIT_CLOCK, PCM_SERIAL_DATA,
               STREAM_LEFT_DATA, STREAM_RIGHT_DATA, STREAM_BIT_CLOCK,
               CTRL_CLOCK, CTRL_SELECT_N, CTRL_DATA_IN}),
    .sync    (pins_s)
  );
  assign {wclk_s, bclk_s, pdat_s, sl_s, sr_s, sbclk_s,
          cclk_s, csel_s, cdin_s} = pins_s;

  // initialisation after reset release, registers held at default
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      init_cnt  <= '0;
      INIT_BUSY <= 1'b1;
    end else if (INIT_BUSY) begin
      init_cnt <= init_cnt + 11'h001;
      if (init_cnt == INIT_LAST) INIT_BUSY <= 1'b0;
    end
  end

  // control port lives on its own clock, seen here through sync
  dacip_ctrl_port u_ctrl (
    .clk      (CLK),
    .reset_n  (RESET_N),
    .sclk     (cclk_s),
    .sel_n    (csel_s),
    .sdi      (cdin_s),
    .index    (ctrl_idx),
    .rd_data  (ctrl_rd16[7:0]),
    .wr_pulse (ctrl_wr),
    .wr_data  (ctrl_wdata),
    .sdo      (CTRL_DATA_OUT),
    .sdo_oe_n (CTRL_DATA_OE_N)
  );

  // mode registers
  logic [2:0]          fmt;
  logic                bypass_en;
  logic                stereo_sel;
  logic                stream_mode;
  assign fmt         = mode_reg[2][dacip_pkg::FMT_LSB +: 3];
  assign stereo_sel  = mode_reg[3][dacip_pkg::STEREO_SEL_BIT];
  assign bypass_en   = mode_reg[4][dacip_pkg::BYPASS_BIT];
  assign stream_mode = mode_reg[4][dacip_pkg::STREAM_BIT];

  assign bus_idx = AVS_ADDRESS[dacip_pkg::ADDR_LSB +: 7];
  assign bus_wr  = AVS_WRITE && !AVS_WAITREQUEST;

  // serial write beats a bus write to the same register
  generate
    for (genvar i = 0; i < dacip_pkg::MODE_COUNT; i++) begin : g_mode
      localparam logic [6:0] IDX = 7'(dacip_pkg::MODE_FIRST + 7'(i));
      always_ff @(posedge CLK or negedge RESET_N) begin
        if (!RESET_N) mode_reg[i] <= dacip_pkg::MODE_RST[i];
        else if (INIT_BUSY) mode_reg[i] <= dacip_pkg::MODE_RST[i];
        else if (ctrl_wr && ctrl_idx == IDX)
          mode_reg[i] <= ctrl_wdata;
        else if (bus_wr && bus_idx == IDX)
          mode_reg[i] <= AVS_WRITEDATA[7:0];
      end
    end
  endgenerate

  // ratio detection and drift watch
  dacip_pkg::dacip_lock_e lock_state;
  logic        wclk_prev;
  logic        wrise;
  logic [10:0] period_cnt;
  logic [10:0] period_meas;
  logic [10:0] new_period;
  logic [2:0]  new_code;
  logic [2:0]  ratio_code;
  logic [10:0] lock_ratio;
  logic [10:0] phase;
  logic [10:0] phase_dev;
  logic [13:0] drift_tol;

  assign wrise      = wclk_s & ~wclk_prev;
  assign new_period = period_cnt + 11'h001;

  // nearest supported ratio within tolerance
  always_comb begin
    new_code = dacip_pkg::RATIO_NONE;
    for (int r = 0; r < dacip_pkg::RATIO_COUNT; r++) begin
      if (new_period + RATIO_TOL >= dacip_pkg::RATIOS[r] &&
          new_period <= dacip_pkg::RATIOS[r] + RATIO_TOL)
        new_code = 3'(r);
    end
  end

  always_comb begin
    phase_dev = (phase < (lock_ratio >> 1)) ? phase : lock_ratio - phase;
    drift_tol = 14'((14'(dacip_pkg::DRIFT_BIT_CLKS) * 14'(lock_ratio))
                >> BITS_PER_FRAME_LOG2);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      wclk_prev   <= 1'b0;
      period_cnt  <= '0;
      period_meas <= '0;
    end else begin
      wclk_prev <= wclk_s;
      if (wrise) begin
        period_cnt  <= '0;
        period_meas <= new_period;
      end else if (period_cnt != 11'h7ff) begin
        period_cnt <= new_period;
      end
    end
  end

  // word clock only needs a stable ratio, not a set phase
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      lock_state <= dacip_pkg::LOCK_SEARCH;
      ratio_code <= dacip_pkg::RATIO_NONE;
      lock_ratio <= dacip_pkg::RATIOS[0];
      phase      <= '0;
    end else begin
      unique case (lock_state)
        dacip_pkg::LOCK_SEARCH: begin
          if (wrise && new_code != dacip_pkg::RATIO_NONE) begin
            lock_state <= dacip_pkg::LOCK_HELD;
            ratio_code <= new_code;
            lock_ratio <= dacip_pkg::RATIOS[new_code];
            phase      <= 11'h001;
          end
        end
        dacip_pkg::LOCK_HELD: begin
          phase <= (phase == lock_ratio - 11'h001) ? '0
                   : phase + 11'h001;
          // a stopped word clock also drops the lock
          if ((wrise && 14'(phase_dev) > drift_tol) ||
              period_cnt == 11'h7ff) begin
            lock_state <= dacip_pkg::LOCK_SEARCH;
            ratio_code <= dacip_pkg::RATIO_NONE;
          end
        end
      endcase
    end
  end

  // audio serial input
  logic        bclk_prev;
  logic        brise;
  logic        path_on;
  logic        lr_seen;
  logic [5:0]  bit_cnt;
  logic [23:0] shift_a;
  logic [23:0] shift_b;
  logic        is_i2s;
  logic        is_rj;
  logic [4:0]  width;
  logic        boundary;
  logic [5:0]  this_bit;
  logic        take;
  logic        d_a;
  logic        stereo_byp;
  logic        left_level;
  logic [23:0] aligned_a;
  logic [23:0] aligned_b;

  assign brise      = bclk_s & ~bclk_prev;
  assign path_on    = !INIT_BUSY && !stream_mode
                      && lock_state == dacip_pkg::LOCK_HELD;
  assign stereo_byp = bypass_en && stereo_sel;
  assign d_a        = stereo_byp ? sl_s : pdat_s;
  assign boundary   = wclk_s != lr_seen;
  assign this_bit   = boundary ? 6'h00 : bit_cnt;

  always_comb begin
    is_i2s = !bypass_en && (fmt == dacip_pkg::FMT_I2S16 ||
                            fmt == dacip_pkg::FMT_I2S24);
    is_rj  = bypass_en || fmt == dacip_pkg::FMT_RJ16 ||
             fmt == dacip_pkg::FMT_RJ20 || fmt == dacip_pkg::FMT_RJ24;
    if (bypass_en) width = 5'(dacip_pkg::SAMPLE_W);
    else if (fmt == dacip_pkg::FMT_RJ16 || fmt == dacip_pkg::FMT_I2S16)
      width = 5'd16;
    else if (fmt == dacip_pkg::FMT_RJ20) width = 5'd20;
    else width = 5'(dacip_pkg::SAMPLE_W);
    // i2s word starts one bit after the word clock edge
    if (is_rj) take = 1'b1;
    else if (is_i2s) take = this_bit >= 6'h01 && this_bit <= 6'(width);
    else take = this_bit < 6'(width);
    left_level = !is_i2s;
    // msb-first word left-aligned, low bits zero, sign kept
    aligned_a = shift_a << (5'(dacip_pkg::SAMPLE_W) - width);
    aligned_b = shift_b << (5'(dacip_pkg::SAMPLE_W) - width);
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      bclk_prev <= 1'b0;
      lr_seen   <= 1'b0;
      bit_cnt   <= '0;
      shift_a   <= '0;
      shift_b   <= '0;
    end else begin
      bclk_prev <= bclk_s;
      if (brise && path_on) begin
        if (take) shift_a <= {shift_a[22:0], d_a};
        if (take) shift_b <= {shift_b[22:0], sr_s};
        lr_seen <= wclk_s;
        if (boundary) bit_cnt <= 6'h01;
        else if (bit_cnt != 6'h3f) bit_cnt <= bit_cnt + 6'h01;
      end
    end
  end

  // bipolar zero whenever the path is not locked and running
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LEFT_SAMPLE  <= '0;
      RIGHT_SAMPLE <= '0;
      SAMPLE_VALID <= 1'b0;
      OUTPUT_MUTED <= 1'b1;
    end else begin
      SAMPLE_VALID <= 1'b0;
      OUTPUT_MUTED <= !path_on;
      if (!path_on) begin
        LEFT_SAMPLE  <= '0;
        RIGHT_SAMPLE <= '0;
      end else if (brise && boundary) begin
        if (stereo_byp) begin
          if (lr_seen) begin
            LEFT_SAMPLE  <= aligned_a;
            RIGHT_SAMPLE <= aligned_b;
            SAMPLE_VALID <= 1'b1;
          end
        end else if (lr_seen == left_level) begin
          LEFT_SAMPLE <= aligned_a;
        end else begin
          RIGHT_SAMPLE <= aligned_a;
          SAMPLE_VALID <= 1'b1;
        end
      end
    end
  end

  // one-bit stream input
  logic sbclk_prev;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sbclk_prev       <= 1'b0;
      STREAM_LEFT_BIT  <= 1'b0;
      STREAM_RIGHT_BIT <= 1'b0;
      STREAM_VALID     <= 1'b0;
    end else begin
      sbclk_prev   <= sbclk_s;
      STREAM_VALID <= 1'b0;
      if (sbclk_s && !sbclk_prev && stream_mode && !INIT_BUSY) begin
        STREAM_LEFT_BIT  <= sl_s;
        STREAM_RIGHT_BIT <= sr_s;
        STREAM_VALID     <= 1'b1;
      end
    end
  end

  // register read view shared by both ports
  function automatic logic [15:0] read_reg(input logic [6:0] idx);
    logic [6:0] off;
    off = idx - dacip_pkg::MODE_FIRST;
    if (idx >= dacip_pkg::MODE_FIRST &&
        off < 7'(dacip_pkg::MODE_COUNT))
      read_reg = {8'h00, mode_reg[off[2:0]]};
    else if (idx == dacip_pkg::IDX_STATUS)
      read_reg = {11'h000, ratio_code,
                  lock_state == dacip_pkg::LOCK_HELD, INIT_BUSY};
    else if (idx == dacip_pkg::IDX_PERIOD)
      read_reg = {5'h00, period_meas};
    else
      read_reg = 16'h0000;
  endfunction

  assign ctrl_rd16 = read_reg(ctrl_idx);

  // one wait state per access, then the answer
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      AVS_WAITREQUEST <= 1'b1;
      AVS_READDATA    <= '0;
    end else begin
      AVS_WAITREQUEST <= !((AVS_READ || AVS_WRITE) && AVS_WAITREQUEST);
      if (AVS_READ && AVS_WAITREQUEST)
        AVS_READDATA <= {16'h0000, read_reg(bus_idx)};
    end
  end
endmodule

// File: testbench/dacip_top_properties.sv
// port assertions for the audio input and control port top
`timescale 1ns/10ps
module dacip_top_checker #(
  parameter int INIT_CYCLES = 1024
) (
  // clock and reset
  input wire logic        CLK,
  input wire logic        RESET_N,
  // register bus
  input wire logic        AVS_READ,
  input wire logic        AVS_WRITE,
  input wire logic [31:0] AVS_READDATA,
  input wire logic        AVS_WAITREQUEST,
  // serial control
  input wire logic        CTRL_SELECT_N,
  input wire logic        CTRL_DATA_OE_N,
  // audio and status
  input wire logic [23:0] LEFT_SAMPLE,
  input wire logic [23:0] RIGHT_SAMPLE,
  input wire logic        SAMPLE_VALID,
  input wire logic        STREAM_VALID,
  input wire logic        INIT_BUSY,
  input wire logic        OUTPUT_MUTED
);
  int init_cnt;
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) init_cnt <= 0;
    else if (INIT_BUSY) init_cnt <= init_cnt + 1;
  end
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  wait_one_a: assert property (
    (AVS_READ || AVS_WRITE) && AVS_WAITREQUEST |=> !AVS_WAITREQUEST)
    else $error("bus answer not one cycle after request");
  wait_short_a: assert property (
    !AVS_WAITREQUEST |=> AVS_WAITREQUEST)
    else $error("waitrequest low longer than one cycle");
  wait_cause_a: assert property (
    $fell(AVS_WAITREQUEST) |-> $past(AVS_READ || AVS_WRITE))
    else $error("bus answer without request");
  read_upper_a: assert property (
    !AVS_WAITREQUEST |-> AVS_READDATA[31:16] == 16'h0000)
    else $error("upper read data not zero");
  init_len_a: assert property (
    $fell(INIT_BUSY) |-> init_cnt >= INIT_CYCLES
                         && init_cnt <= INIT_CYCLES + 1)
    else $error("init length wrong");
  init_mute_a: assert property (
    INIT_BUSY |-> OUTPUT_MUTED)
    else $error("outputs live during init");
  mute_zero_a: assert property (
    OUTPUT_MUTED && $past(OUTPUT_MUTED) |->
      LEFT_SAMPLE == 24'h000000 && RIGHT_SAMPLE == 24'h000000)
    else $error("muted samples not zero");
  valid_pulse_a: assert property (
    SAMPLE_VALID |=> !SAMPLE_VALID)
    else $error("sample valid longer than one cycle");
  stream_pulse_a: assert property (
    STREAM_VALID |=> !STREAM_VALID)
    else $error("stream valid longer than one cycle");
  oe_release_a: assert property (
    CTRL_SELECT_N [*4] |-> CTRL_DATA_OE_N)
    else $error("data out driven while deselected");
endmodule
bind dacip_top dacip_top_checker #(.INIT_CYCLES(INIT_CYCLES)) i_chk (
  .CLK(CLK), .RESET_N(RESET_N), .AVS_READ(AVS_READ),
  .AVS_WRITE(AVS_WRITE), .AVS_READDATA(AVS_READDATA),
  .AVS_WAITREQUEST(AVS_WAITREQUEST), .CTRL_SELECT_N(CTRL_SELECT_N),
  .CTRL_DATA_OE_N(CTRL_DATA_OE_N), .LEFT_SAMPLE(LEFT_SAMPLE),
  .RIGHT_SAMPLE(RIGHT_SAMPLE), .SAMPLE_VALID(SAMPLE_VALID),
  .STREAM_VALID(STREAM_VALID), .INIT_BUSY(INIT_BUSY),
  .OUTPUT_MUTED(OUTPUT_MUTED));

// File: testbench/dacip_ctrl_host.sv
// host model driving the four-wire serial control port
`timescale 1ns/10ps
module dacip_ctrl_host (
  // control pins
  output logic      ctrl_clock,
  output logic      ctrl_select_n,
  output logic      ctrl_data_in,
  input  wire logic ctrl_data_out,
  input  wire logic ctrl_data_oe_n
);
  localparam time HALF = 80ns; // own timebase, no tie to CLK
  initial begin
    ctrl_clock = 1'b0;
    ctrl_select_n = 1'b1;
    ctrl_data_in = 1'b0;
  end
  // undriven data line reads as a toggling value, never the last bit
  task automatic xfer(input logic [15:0] w, input int nclk,
                      output logic [7:0] rd);
    rd = 8'h00;
    #3ns;
    ctrl_select_n = 1'b0;
    #(HALF);
    for (int i = 0; i < nclk; i++) begin
      ctrl_data_in = w[15 - i];
      #(HALF);
      ctrl_clock = 1'b1;
      if (i >= 8) rd = {rd[6:0], ctrl_data_oe_n ? ~rd[0] : ctrl_data_out};
      #(HALF);
      ctrl_clock = 1'b0;
    end
    #(HALF);
    ctrl_select_n = 1'b1;
    ctrl_data_in = ~ctrl_data_in;
    #(5 * HALF);
  endtask
endmodule

// File: testbench/tb_dac_input_and_control_port.sv
// self-checking bench for the audio input and control port
`timescale 1ns/10ps
module tb_dac_input_and_control_port;
  localparam int INIT_N = 16;
  logic        clk = 1'b0;
  logic        reset_n = 1'b0;
  logic [8:0]  avs_address = '0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = '0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        pcm_wc = 1'b0, pcm_bc = 1'b0, pcm_sd = 1'b0;
  logic        st_l = 1'b0, st_r = 1'b0, st_bc = 1'b0;
  logic        c_clk, c_sel_n, c_din, c_dout, c_oe_n;
  logic [23:0] left_s, right_s, got_l, got_r;
  logic        s_valid, st_lb, st_rb, st_valid, init_busy, muted;
  logic [1:0]  got_s;
  logic [31:0] d;
  logic [7:0]  rd;
  int          n_errors = 0, cmp_count = 0, cyc = 0;

  always #5 clk = ~clk;
  dacip_top #(.INIT_CYCLES(INIT_N)) i_dut (
    .CLK(clk), .RESET_N(reset_n), .AVS_ADDRESS(avs_address),
    .AVS_READ(avs_read), .AVS_WRITE(avs_write),
    .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
    .AVS_WAITREQUEST(avs_waitrequest), .PCM_WORD_CLOCK(pcm_wc),
    .PCM_BIT_CLOCK(pcm_bc), .PCM_SERIAL_DATA(pcm_sd),
    .STREAM_LEFT_DATA(st_l), .STREAM_RIGHT_DATA(st_r),
    .STREAM_BIT_CLOCK(st_bc), .CTRL_CLOCK(c_clk),
    .CTRL_SELECT_N(c_sel_n), .CTRL_DATA_IN(c_din),
    .CTRL_DATA_OUT(c_dout), .CTRL_DATA_OE_N(c_oe_n),
    .LEFT_SAMPLE(left_s), .RIGHT_SAMPLE(right_s),
    .SAMPLE_VALID(s_valid), .STREAM_LEFT_BIT(st_lb),
    .STREAM_RIGHT_BIT(st_rb), .STREAM_VALID(st_valid),
    .INIT_BUSY(init_busy), .OUTPUT_MUTED(muted));
  dacip_ctrl_host i_host (
    .ctrl_clock(c_clk), .ctrl_select_n(c_sel_n), .ctrl_data_in(c_din),
    .ctrl_data_out(c_dout), .ctrl_data_oe_n(c_oe_n));

  always @(posedge clk) begin
    if (s_valid === 1'b1) {got_l, got_r} <= {left_s, right_s};
    if (st_valid === 1'b1) got_s <= {st_lb, st_rb};
  end
  always @(posedge clk) begin
    cyc++;
    if (cyc == 40000) begin
      n_errors++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, n_errors);
    if (n_errors == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [6:0] idx,
                     input logic [7:0] wd);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h000000, wd};
    if (wr) avs_write <= 1'b1;
    else avs_read <= 1'b1;
    do begin
      @(posedge clk);
    end while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wait_init();
    int k;
    k = 0;
    while (init_busy !== 1'b0 && k < 200) begin
      @(posedge clk);
      k++;
    end
  endtask
  // 12-CLK bits, 64 a frame: 768x at 130 kHz, no 128x mode
  task automatic pcm_frames(input logic left_lvl, input int msb_delay,
                            input logic [23:0] l, r);
    logic [23:0] v;
    int p;
    for (int f = 0; f < 6; f++)
      for (int h = 0; h < 2; h++)
        for (int b = 0; b < 32; b++) begin
          v = h ? r : l;
          p = b - msb_delay;
          pcm_wc <= h ? ~left_lvl : left_lvl;
          pcm_sd <= (p >= 0 && p < 24) ? v[23 - p] : 1'b0;
          pcm_bc <= 1'b0;
          repeat (6) @(posedge clk);
          pcm_bc <= 1'b1;
          repeat (6) @(posedge clk);
        end
  endtask

  initial begin
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    bus(1'b0, dacip_pkg::IDX_STATUS, 8'h00);
    chk("init flag", d & 32'h1, 32'h1);
    bus(1'b1, dacip_pkg::IDX_ATTN_LEFT, 8'hff);
    wait_init();
    chk("init done", init_busy, 1'b0);
    for (int i = 0; i < dacip_pkg::MODE_COUNT; i++) begin
      bus(1'b0, dacip_pkg::MODE_FIRST + 7'(i), 8'h00);
      chk("mode default", d, dacip_pkg::MODE_RST[i]);
    end
    bus(1'b0, dacip_pkg::IDX_FORMAT_CTRL, 8'h00);
    chk("fmt default", d, dacip_pkg::MODE_RST[2]);
    chk("format", d, {25'h0, dacip_pkg::FMT_I2S24, 4'h0});
    bus(1'b1, 7'h00, 8'hff);
    bus(1'b0, 7'h00, 8'h00);
    chk("unmapped", d, 32'h0);
    i_host.xfer({1'b0, dacip_pkg::IDX_ATTN_LEFT, 8'ha5}, 16, rd);
    @(posedge clk);
    bus(1'b0, dacip_pkg::IDX_ATTN_LEFT, 8'h00);
    chk("serial write", d, 32'ha5);
    i_host.xfer({1'b0, dacip_pkg::IDX_ATTN_LEFT, 8'h3c}, 12, rd);
    @(posedge clk);
    bus(1'b0, dacip_pkg::IDX_ATTN_LEFT, 8'h00);
    chk("short word", d, 32'ha5);
    bus(1'b1, dacip_pkg::IDX_ATTN_RIGHT, 8'h96);
    i_host.xfer({1'b1, dacip_pkg::IDX_ATTN_RIGHT, 8'h00}, 16, rd);
    chk("serial read", rd, 8'h96);
    @(posedge clk);
    for (int k = 0; k < 3; k++) begin
      if (k > 0) bus(1'b1, dacip_pkg::IDX_FORMAT_CTRL, {1'b0, (k == 1 ?
          dacip_pkg::FMT_LJ24 : dacip_pkg::FMT_RJ24), 4'h0});
      pcm_frames(k > 0, k == 2 ? 8 : 1 - k, 24'h123456 + 24'(k),
                 24'hfedcba - 24'(k));
      chk("left", got_l, 24'h123456 + 24'(k));
      chk("right", got_r, 24'hfedcba - 24'(k));
      chk("unmuted", muted, 1'b0);
      bus(1'b0, dacip_pkg::IDX_STATUS, 8'h00);
      chk("ratio", d & 32'h1e, 32'h16);
    end
    pcm_wc <= 1'b0;
    pcm_bc <= 1'b0;
    bus(1'b1, dacip_pkg::IDX_MODE_CTRL, 8'h20);
    for (int i = 0; i < 4; i++) begin
      {st_l, st_r, st_bc} <= {i[0], i[1], 1'b0};
      repeat (8) @(posedge clk);
      st_bc <= 1'b1;
      repeat (8) @(posedge clk);
      chk("stream bits", got_s, {i[0], i[1]});
    end
    chk("stream mute", muted, 1'b1);
    reset_n <= 1'b0;
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    wait_init();
    bus(1'b0, dacip_pkg::IDX_ATTN_LEFT, 8'h00);
    chk("reset default", d, 32'h0);
    report_and_stop();
  end
endmodule
